// ===== flash_map.vh
/*
 * constants for the flash block map, programming units and context gating.
 * assumes: included by its bare name from the flash design files.
 */
// Notes on behaviour
// [RULE1] array of 52 kbytes in seven erase blocks: 4x1k, 28k, 16k, 4k.
// [RULE2] blocks end at 0FFF (four 1k), 7FFF, BFFF and CFFF.
// [RULE3] a program operation writes one whole 128-byte unit.
// [RULE4] a unit starts where the low eight bits are 00 or 80.
// [RULE5] an erase clears exactly one block, never several.
// [RULE6] software clears the whole array by erasing each block in turn.
// [RULE7] boot loader may touch the whole array; user mode works per block.
// [RULE8] in boot mode the serial bit rate is measured and matched.
// [RULE9] an external programmer may also erase and program.
// [RULE10] software protection blocks program and erase when engaged.
// [RULE11] subactive mode powers the array down partly, reads still allowed.
// [RULE12] clock-stop bit 0 stops the module clock, 1 restores it.
// [RULE13] with the debugger in use software keeps the flash clock bit at 1.
// [RULE14] addresses past the last block decode to no block, nothing changes.
`ifndef FLASH_MAP_VH
`define FLASH_MAP_VH
`define ADDR_W          16
`define BLK_W           3
`define NUM_BLKS        3'h7
`define BLK_NONE        3'h7
`define BLK0_END        16'h03FF
`define BLK1_END        16'h07FF
`define BLK2_END        16'h0BFF
`define BLK3_END        16'h0FFF
`define BLK4_END        16'h7FFF
`define BLK5_END        16'hBFFF
`define BLK6_END        16'hCFFF
`define UNIT_BYTES      8'h80
`define UNIT_OFS_MSB    6
`define UNIT_OFS_ZERO   7'h00
`define LOW_BYTE_MSB    7
`define CTX_USER        2'h0
`define CTX_BOOT        2'h1
`define CTX_PROG        2'h2
`define ST_IDLE         2'h0
`define ST_PROG         2'h1
`define ST_ERASE        2'h2
`define FLASH_RUN_BIT   1
`define BAUD_CNT_W      16
`endif

// ===== flash_baud_meter.v
/*
 * measures the width of the host's first low pulse on the boot serial line
 * and reports it as the bit period in clock cycles.
 * assumes: rx_i is already synchronised to clk_i.
 */
`timescale 1ns/1ps
`include "flash_map.vh"
module flash_baud_meter #(
    parameter CNT_W = `BAUD_CNT_W
) (
    input  wire             clk_i,
    input  wire             rst_i,
    input  wire             arm_i,
    input  wire             rx_i,
    output reg  [CNT_W-1:0] period_o,
    output reg              locked_o
);
    reg [CNT_W-1:0] cnt_r;
    reg             meas_r;
    reg             rx_d_r;
    always @(posedge clk_i) begin
        if (rst_i) begin
            cnt_r    <= {CNT_W{1'b0}};
            meas_r   <= 1'b0;
            rx_d_r   <= 1'b1;
            period_o <= {CNT_W{1'b0}};
            locked_o <= 1'b0;
        end else begin
            rx_d_r <= rx_i;
            if (!arm_i) begin
                meas_r   <= 1'b0;
                locked_o <= 1'b0;
            end else if (!locked_o) begin
                // a start bit of known width sets the rate [RULE8]
                if (rx_d_r && !rx_i) begin
                    meas_r <= 1'b1;
                    cnt_r  <= {{(CNT_W-1){1'b0}}, 1'b1};
                end else if (meas_r && !rx_i && cnt_r != {CNT_W{1'b1}}) begin
                    cnt_r <= cnt_r + {{(CNT_W-1){1'b0}}, 1'b1};
                end else if (meas_r && rx_i) begin
                    meas_r   <= 1'b0;
                    period_o <= cnt_r;
                    locked_o <= 1'b1;
                end
            end
        end
    end
endmodule

// ===== flash_block_map_and_gating.v
/*
 * flash array front end: address to erase-block decode, 128-byte unit
 * checks, context selection, protection, low-power read and module standby.
 * assumes: the cpu holds a request level for one cycle; the array core
 * performs the cell work signalled by the strobes and replies with done.
 */
`timescale 1ns/1ps
`include "flash_map.vh"
module flash_block_map_and_gating #(
    parameter ADDR_W = `ADDR_W
) (
    input  wire              CLOCK_I,
    input  wire              RST_I,
    input  wire [ADDR_W-1:0] ADDR_I,
    input  wire              PROG_REQ_I,
    input  wire              ERASE_REQ_I,
    input  wire              ERASE_ALL_I,
    input  wire              READ_REQ_I,
    input  wire              BOOT_MODE_I,
    input  wire              PROGRAMMER_MODE_I,
    input  wire              PROTECT_I,
    input  wire              SUBACTIVE_I,
    input  wire              FLASH_RUN_I,
    input  wire              SERIAL_RX_I,
    input  wire              CORE_DONE_I,
    output reg  [2:0]        BLOCK_O,
    output reg               BLOCK_VALID_O,
    output reg               PROG_STROBE_O,
    output reg  [ADDR_W-1:0] PROG_BASE_O,
    output reg               ERASE_STROBE_O,
    output reg  [6:0]        ERASE_SEL_O,
    output reg               BUSY_O,
    output reg               REJECT_O,
    output reg  [1:0]        CONTEXT_O,
    output reg               LOW_POWER_O,
    output reg               READ_OK_O,
    output reg               CLOCK_EN_O,
    output wire [15:0]       BAUD_PERIOD_O,
    output wire              BAUD_LOCKED_O
);
    // decode an address to its erase block [RULE1] [RULE2] [RULE14]
    function [2:0] blk_of;
        input [ADDR_W-1:0] a;
        begin
            if      (a <= `BLK0_END) blk_of = 3'h0;
            else if (a <= `BLK1_END) blk_of = 3'h1;
            else if (a <= `BLK2_END) blk_of = 3'h2;
            else if (a <= `BLK3_END) blk_of = 3'h3;
            else if (a <= `BLK4_END) blk_of = 3'h4;
            else if (a <= `BLK5_END) blk_of = 3'h5;
            else if (a <= `BLK6_END) blk_of = 3'h6;
            else                     blk_of = `BLK_NONE;
        end
    endfunction

    // one-hot select so only one block is ever erased [RULE5]
    function [6:0] onehot;
        input [2:0] b;
        begin
            onehot = (b == `BLK_NONE) ? 7'h00 : (7'h01 << b);
        end
    endfunction

    // boot and programmer mode pins and the serial line pass two flip-flops
    reg [1:0] boot_s_r;
    reg [1:0] pmode_s_r;
    reg [1:0] rx_s_r;
    always @(posedge CLOCK_I) begin
        if (RST_I) begin
            boot_s_r  <= 2'h0;
            pmode_s_r <= 2'h0;
            rx_s_r    <= 2'h3;
        end else begin
            boot_s_r  <= {boot_s_r[0], BOOT_MODE_I};
            pmode_s_r <= {pmode_s_r[0], PROGRAMMER_MODE_I};
            rx_s_r    <= {rx_s_r[0], SERIAL_RX_I};
        end
    end
    wire boot_w  = boot_s_r[1];
    wire pmode_w = pmode_s_r[1];

    flash_baud_meter #(
        .CNT_W    (16)
    ) u_baud (
        .clk_i    (CLOCK_I),
        .rst_i    (RST_I),
        .arm_i    (boot_w),
        .rx_i     (rx_s_r[1]),
        .period_o (BAUD_PERIOD_O),
        .locked_o (BAUD_LOCKED_O)
    );

    wire [2:0] blk_w      = blk_of(ADDR_I);
    wire       in_map_w   = (blk_w != `BLK_NONE);
    // unit must start on 00 or 80 of the low byte [RULE3] [RULE4]
    wire       aligned_w  = (ADDR_I[`UNIT_OFS_MSB:0] == `UNIT_OFS_ZERO);
    wire [1:0] ctx_w      = pmode_w ? `CTX_PROG : (boot_w ? `CTX_BOOT : `CTX_USER);
    // programmer mode works from its own unit, protection is software's [RULE9] [RULE10]
    wire       locked_w   = PROTECT_I && (ctx_w != `CTX_PROG);
    wire       clk_run_w  = FLASH_RUN_I; // [RULE12] [RULE13]

    reg [1:0] st_r;
    reg [1:0] st_nxt;
    reg [2:0] sweep_r;
    reg [2:0] sweep_nxt;
    reg       sweeping_r;
    reg       sweeping_nxt;

    always @* begin
        st_nxt       = st_r;
        sweep_nxt    = sweep_r;
        sweeping_nxt = sweeping_r;
        case (st_r)
            `ST_IDLE: begin
                if (sweeping_r) begin
                    st_nxt = `ST_ERASE;
                end
            end
            `ST_PROG: begin
                if (CORE_DONE_I) begin
                    st_nxt = `ST_IDLE;
                end
            end
            `ST_ERASE: begin
                if (CORE_DONE_I) begin
                    st_nxt = `ST_IDLE;
                    // the loader steps block by block for a full clear [RULE6] [RULE7]
                    if (sweeping_r) begin
                        if (sweep_r == `NUM_BLKS - 3'h1) begin
                            sweeping_nxt = 1'b0;
                        end else begin
                            sweep_nxt = sweep_r + 3'h1;
                        end
                    end
                end
            end
            default: st_nxt = `ST_IDLE;
        endcase
    end

    always @(posedge CLOCK_I) begin
        if (RST_I) begin
            st_r           <= `ST_IDLE;
            sweep_r        <= 3'h0;
            sweeping_r     <= 1'b0;
            BLOCK_O        <= `BLK_NONE;
            BLOCK_VALID_O  <= 1'b0;
            PROG_STROBE_O  <= 1'b0;
            PROG_BASE_O    <= {ADDR_W{1'b0}};
            ERASE_STROBE_O <= 1'b0;
            ERASE_SEL_O    <= 7'h00;
            BUSY_O         <= 1'b0;
            REJECT_O       <= 1'b0;
            CONTEXT_O      <= `CTX_USER;
            LOW_POWER_O    <= 1'b0;
            READ_OK_O      <= 1'b0;
            CLOCK_EN_O     <= 1'b1;
        end else begin
            st_r           <= st_nxt;
            sweep_r        <= sweep_nxt;
            sweeping_r     <= sweeping_nxt;
            PROG_STROBE_O  <= 1'b0;
            ERASE_STROBE_O <= 1'b0;
            REJECT_O       <= 1'b0;
            READ_OK_O      <= 1'b0;
            BLOCK_O        <= blk_w;
            BLOCK_VALID_O  <= in_map_w;
            CONTEXT_O      <= ctx_w;
            CLOCK_EN_O     <= clk_run_w;
            // power supply partly off, reads still served [RULE11]
            LOW_POWER_O    <= SUBACTIVE_I;
            if (clk_run_w && READ_REQ_I && in_map_w) begin
                READ_OK_O <= 1'b1;
            end
            // a stopped module takes no work; busy state is frozen [RULE12]
            if (!clk_run_w) begin
                st_r       <= st_r;
                sweep_r    <= sweep_r;
                sweeping_r <= sweeping_r;
                REJECT_O   <= PROG_REQ_I | ERASE_REQ_I | ERASE_ALL_I;
            end else if (st_r == `ST_IDLE && sweeping_r) begin
                ERASE_STROBE_O <= 1'b1;
                ERASE_SEL_O    <= onehot(sweep_r); // [RULE5]
                BUSY_O         <= 1'b1;
            end else if (st_r == `ST_IDLE && (PROG_REQ_I || ERASE_REQ_I || ERASE_ALL_I)) begin
                // low-power read state refuses cell changes as well
                if (locked_w || SUBACTIVE_I) begin
                    REJECT_O <= 1'b1; // [RULE10]
                end else if (ERASE_ALL_I) begin
                    if (ctx_w == `CTX_USER) begin
                        REJECT_O <= 1'b1; // [RULE7]
                    end else begin
                        sweeping_r <= 1'b1;
                        sweep_r    <= 3'h0;
                        BUSY_O     <= 1'b1;
                    end
                end else if (!in_map_w) begin
                    REJECT_O <= 1'b1; // [RULE14]
                end else if (PROG_REQ_I) begin
                    if (aligned_w) begin
                        PROG_STROBE_O <= 1'b1; // [RULE3] [RULE4]
                        PROG_BASE_O   <= ADDR_I;
                        BUSY_O        <= 1'b1;
                        st_r          <= `ST_PROG;
                    end else begin
                        REJECT_O <= 1'b1;
                    end
                end else begin
                    ERASE_STROBE_O <= 1'b1;
                    ERASE_SEL_O    <= onehot(blk_w); // [RULE5]
                    BUSY_O         <= 1'b1;
                    st_r           <= `ST_ERASE;
                end
            end else if (st_nxt == `ST_IDLE && st_r != `ST_IDLE && !sweeping_nxt) begin
                BUSY_O <= 1'b0;
            end
        end
    end
endmodule

// ===== flash_core_model.sv
/*
 * array core stand-in: answers every program or erase strobe with a done pulse.
 * assumes: strobes are single-cycle pulses on clk_i.
 */
`timescale 1ns/1ps
module flash_core_model #(
    parameter int DELAY = 5
) (
    input  wire logic clk_i,
    input  wire logic rst_i,
    input  wire logic prog_strobe_i,
    input  wire logic erase_strobe_i,
    output logic      done_o
);
    int cnt_r = 0;
    initial done_o = 1'b0;
    // one unit or one block per strobe, so one done per strobe
    always @(posedge clk_i) begin
        done_o <= 1'b0;
        if (rst_i) begin
            cnt_r <= 0;
        end else if (prog_strobe_i || erase_strobe_i) begin
            cnt_r <= DELAY;
        end else if (cnt_r == 1) begin
            cnt_r <= 0;
            done_o <= 1'b1;
        end else if (cnt_r > 1) begin
            cnt_r <= cnt_r - 1;
        end
    end
endmodule

// ===== flash_map_monitor.sv
/*
 * checker for the flash block map front end.
 * assumes: bound to flash_block_map_and_gating, one clock domain.
 */
`timescale 1ns/1ps
module flash_map_monitor #(
    parameter ADDR_W = 16
) (
    input wire logic              CLOCK_I,
    input wire logic              RST_I,
    input wire logic [ADDR_W-1:0] ADDR_I,
    input wire logic              PROG_REQ_I,
    input wire logic              ERASE_ALL_I,
    input wire logic              PROTECT_I,
    input wire logic              SUBACTIVE_I,
    input wire logic              FLASH_RUN_I,
    input wire logic [2:0]        BLOCK_O,
    input wire logic              PROG_STROBE_O,
    input wire logic [ADDR_W-1:0] PROG_BASE_O,
    input wire logic              ERASE_STROBE_O,
    input wire logic [6:0]        ERASE_SEL_O,
    input wire logic              BUSY_O,
    input wire logic              REJECT_O,
    input wire logic [1:0]        CONTEXT_O,
    input wire logic              LOW_POWER_O,
    input wire logic              CLOCK_EN_O
);
    default clocking cb @(posedge CLOCK_I); endclocking
    default disable iff (RST_I);
    function automatic [2:0] blk_f(input [15:0] a);
        blk_f = (a <= 16'h0FFF) ? a[12:10] : (a <= 16'h7FFF) ? 3'h4 : (a <= 16'hBFFF) ? 3'h5
              : (a <= 16'hCFFF) ? 3'h6 : 3'h7;
    endfunction
    property p_unit_base;
        PROG_STROBE_O |-> PROG_BASE_O[6:0] == 7'h00 && $past(PROG_REQ_I);
    endproperty
    a_unit_base: assert property (p_unit_base) else $error("program unit base misaligned");
    property p_in_range;
        PROG_STROBE_O |-> PROG_BASE_O <= 16'hCFFF;
    endproperty
    a_in_range: assert property (p_in_range) else $error("program beyond last block");
    property p_decode;
        !$past(RST_I) && $past(FLASH_RUN_I) |-> BLOCK_O == blk_f($past(ADDR_I));
    endproperty
    a_decode: assert property (p_decode) else $error("block decode wrong");
    property p_one_block;
        ERASE_STROBE_O |-> $onehot(ERASE_SEL_O) && !PROG_STROBE_O;
    endproperty
    a_one_block: assert property (p_one_block) else $error("erase selects not one block");
    property p_protect;
        PROG_STROBE_O |-> !$past(PROTECT_I) || $past(CONTEXT_O) == 2'h2 || CONTEXT_O == 2'h2;
    endproperty
    a_protect: assert property (p_protect) else $error("program while protected");
    property p_sub_block;
        PROG_STROBE_O |-> !$past(SUBACTIVE_I);
    endproperty
    a_sub_block: assert property (p_sub_block) else $error("program in subactive");
    property p_low_power;
        !$past(RST_I) |-> LOW_POWER_O == $past(SUBACTIVE_I);
    endproperty
    a_low_power: assert property (p_low_power) else $error("low power state wrong");
    property p_clock_gate;
        !$past(RST_I) |-> CLOCK_EN_O == $past(FLASH_RUN_I) && (PROG_STROBE_O -> $past(FLASH_RUN_I));
    endproperty
    a_clock_gate: assert property (p_clock_gate) else $error("module clock gate wrong");
    property p_user_sweep;
        ERASE_ALL_I && !BUSY_O && FLASH_RUN_I && CONTEXT_O == 2'h0 |=> REJECT_O && !ERASE_STROBE_O;
    endproperty
    a_user_sweep: assert property (p_user_sweep) else $error("whole erase in user context");
    c_prog: cover property (PROG_STROBE_O);
    c_sweep_end: cover property (ERASE_STROBE_O && ERASE_SEL_O == 7'h40);
    c_reject: cover property (REJECT_O);
endmodule
bind flash_block_map_and_gating flash_map_monitor #(.ADDR_W(ADDR_W)) u_mon (
    .CLOCK_I(CLOCK_I), .RST_I(RST_I), .ADDR_I(ADDR_I), .PROG_REQ_I(PROG_REQ_I), .ERASE_ALL_I(ERASE_ALL_I),
    .PROTECT_I(PROTECT_I), .SUBACTIVE_I(SUBACTIVE_I), .FLASH_RUN_I(FLASH_RUN_I), .BLOCK_O(BLOCK_O),
    .PROG_STROBE_O(PROG_STROBE_O), .PROG_BASE_O(PROG_BASE_O), .ERASE_STROBE_O(ERASE_STROBE_O),
    .ERASE_SEL_O(ERASE_SEL_O), .BUSY_O(BUSY_O), .REJECT_O(REJECT_O), .CONTEXT_O(CONTEXT_O),
    .LOW_POWER_O(LOW_POWER_O), .CLOCK_EN_O(CLOCK_EN_O));

// ===== tb_top.sv
/*
 * self-checking bench for the flash block map front end.
 * assumes: flash_core_model answers each strobe; inputs change at rising edges.
 */
`timescale 1ns/1ps
module tb_top;
    logic        clk = 0, rst = 1, prog = 0, ers = 0, all = 0, rd = 0, boot = 0, pgm = 0;
    logic        prot = 0, sub = 0, run = 1, rx = 1;
    logic [15:0] addr = 16'h0000;
    logic [6:0]  es_mask = 7'h00;
    wire         done, bv, ps, es, busy, rej, lp, rok, cen, bl;
    wire  [2:0]  blk;
    wire  [15:0] base, bp;
    wire  [6:0]  sel;
    wire  [1:0]  ctx;
    int          n_fail = 0, tests_run = 0, cyc = 0, n_es = 0;
    logic [15:0] da [13] = '{16'h0000, 16'h03FF, 16'h0400, 16'h0BFF, 16'h0C00, 16'h0FFF, 16'h1000,
                             16'h7FFF, 16'h8000, 16'hBFFF, 16'hC000, 16'hCFFF, 16'hD000};
    logic [2:0]  db [13] = '{3'h0, 3'h0, 3'h1, 3'h2, 3'h3, 3'h3, 3'h4, 3'h4, 3'h5, 3'h5, 3'h6, 3'h6, 3'h7};
    flash_block_map_and_gating u_dut (.CLOCK_I(clk), .RST_I(rst), .ADDR_I(addr), .PROG_REQ_I(prog),
        .ERASE_REQ_I(ers), .ERASE_ALL_I(all), .READ_REQ_I(rd), .BOOT_MODE_I(boot), .PROGRAMMER_MODE_I(pgm),
        .PROTECT_I(prot), .SUBACTIVE_I(sub), .FLASH_RUN_I(run), .SERIAL_RX_I(rx), .CORE_DONE_I(done),
        .BLOCK_O(blk), .BLOCK_VALID_O(bv), .PROG_STROBE_O(ps), .PROG_BASE_O(base), .ERASE_STROBE_O(es),
        .ERASE_SEL_O(sel), .BUSY_O(busy), .REJECT_O(rej), .CONTEXT_O(ctx), .LOW_POWER_O(lp),
        .READ_OK_O(rok), .CLOCK_EN_O(cen), .BAUD_PERIOD_O(bp), .BAUD_LOCKED_O(bl));
    flash_core_model u_core (.clk_i(clk), .rst_i(rst), .prog_strobe_i(ps), .erase_strobe_i(es), .done_o(done));
    always #50 clk = ~clk;
    task report_and_stop;
        $display("checks %0d mismatches %0d", tests_run, n_fail);
        if (n_fail == 0 && tests_run > 0) $display("ALL TESTS PASSED");
        else $display("TESTS FAILED");
        $finish;
    endtask
    // a hang counts as a mismatch and still reaches the verdict
    always @(posedge clk) begin
        cyc++;
        if (es) begin
            n_es++;
            es_mask |= sel;
        end
        if (cyc == 5000) begin
            n_fail++;
            report_and_stop();
        end
    end
    task chk(input string nm, input logic [15:0] e, input logic [15:0] g);
        tests_run++;
        if (g !== e) begin
            n_fail++;
            $display("mismatch %s expected %h seen %h", nm, e, g);
        end
    endtask
    task tk(input int n);
        repeat (n) @(posedge clk);
    endtask
    // x = {reject, erase strobe, program strobe} one cycle after the request edge
    task op(input logic p, e, a, input logic [15:0] ad, input logic [2:0] x, input logic [6:0] xs);
        @(posedge clk);
        {prog, ers, all, addr} <= {p, e, a, ad};
        @(posedge clk);
        {prog, ers, all} <= 3'b000;
        #1;
        chk("strobes", {13'h0000, x}, {13'h0000, rej, es, ps});
        if (x[0]) chk("base", ad, base);
        if (x[1]) chk("sel", {9'h000, xs}, {9'h000, sel});
        repeat (2000) if (busy) begin
            @(posedge clk);
            #1;
        end
    endtask
    task t_decode;
        for (int i = 0; i < 13; i++) begin
            @(posedge clk);
            addr <= da[i];
            @(posedge clk);
            #1;
            chk("block", {13'h0000, db[i]}, {13'h0000, blk});
            chk("valid", {15'h0000, db[i] != 3'h7}, {15'h0000, bv});
        end
    endtask
    task t_prog;
        op(1, 0, 0, 16'h0080, 3'b001, 7'h00);
        op(1, 0, 0, 16'hCF80, 3'b001, 7'h00);
        op(1, 0, 0, 16'h0140, 3'b100, 7'h00);
        op(1, 0, 0, 16'hD000, 3'b100, 7'h00);
    endtask
    task t_erase;
        for (int i = 0; i < 13; i++)
            op(0, 1, 0, da[i], db[i] == 3'h7 ? 3'b100 : 3'b010, 7'h01 << db[i]);
        op(0, 0, 1, 16'h0000, 3'b100, 7'h00);
    endtask
    task t_protect;
        tk(1);
        prot <= 1'b1;
        op(1, 0, 0, 16'h0100, 3'b100, 7'h00);
        op(0, 1, 0, 16'h0000, 3'b100, 7'h00);
        tk(1);
        pgm <= 1'b1;
        tk(6);
        chk("context", 16'h0002, {14'h0000, ctx});
        op(1, 0, 0, 16'h0100, 3'b001, 7'h00);
        tk(1);
        {pgm, prot} <= 2'b00;
        tk(6);
    endtask
    task t_boot;
        boot <= 1'b1;
        tk(6);
        chk("context", 16'h0001, {14'h0000, ctx});
        rx <= 1'b0;
        tk(20);
        rx <= 1'b1;
        tk(6);
        chk("baud", 16'h0014, bp);
        chk("locked", 16'h0001, {15'h0000, bl});
        {n_es, es_mask} = 0;
        op(0, 0, 1, 16'h0000, 3'b000, 7'h00);
        chk("sweep count", 16'h0007, n_es[15:0]);
        chk("sweep mask", 16'h007F, {9'h000, es_mask});
        tk(1);
        boot <= 1'b0;
        tk(6);
    endtask
    task t_power;
        sub <= 1'b1;
        tk(2);
        #1;
        chk("low power", 16'h0001, {15'h0000, lp});
        op(1, 0, 0, 16'h0200, 3'b100, 7'h00);
        @(posedge clk);
        rd <= 1'b1;
        @(posedge clk);
        rd <= 1'b0;
        #1;
        chk("read ok", 16'h0001, {15'h0000, rok});
        @(posedge clk);
        {sub, run} <= 2'b00;
        tk(2);
        #1;
        chk("clock en", 16'h0000, {15'h0000, cen});
        op(1, 0, 0, 16'h0200, 3'b100, 7'h00);
        tk(1);
        run <= 1'b1;
        op(1, 0, 0, 16'h0280, 3'b001, 7'h00);
        chk("clock en", 16'h0001, {15'h0000, cen});
    endtask
    initial begin
        tk(10);
        rst <= 1'b0;
        // the tenth edge still saw reset, so outputs show their reset values here
        #1;
        chk("reset", 16'h00F0, {busy, blk, cen, ctx, ps, es});
        t_decode();
        t_prog();
        t_erase();
        t_protect();
        t_boot();
        t_power();
        report_and_stop();
    end
endmodule
